// *** afsr_map.svh ***
// Constants for the converter and start-up fault response block
`ifndef AFSR_MAP_SVH
`define AFSR_MAP_SVH

// Response setting field positions
`define AFSR_ACT_HI        7
`define AFSR_ACT_LO        6
`define AFSR_RETRY_HI      5
`define AFSR_RETRY_LO      3
`define AFSR_DELAY_HI      2
`define AFSR_DELAY_LO      0

// Response setting reset value and forced delay field
`define AFSR_RESP_RESET    8'h00
`define AFSR_DELAY_FIXED   3'h0

// Fault source indices
`define AFSR_SRC_HOT       3'h0
`define AFSR_SRC_COLD      3'h1
`define AFSR_SRC_VHI       3'h2
`define AFSR_SRC_VLO       3'h3
`define AFSR_SRC_TON       3'h4

// Summary status bit positions (word; low byte is the byte status)
`define AFSR_SW_VOUT       15
`define AFSR_SW_INPUT      13
`define AFSR_SW_OFF        6
`define AFSR_SW_VIN_UV     3
`define AFSR_SW_TEMP       2
`define AFSR_SW_HIGH_BYTE  0

// Detailed status bit positions
`define AFSR_TEMP_OT       7
`define AFSR_TEMP_UT       6
`define AFSR_VIN_OV        7
`define AFSR_VIN_UV        4
`define AFSR_VOUT_TON      2

// Timebase: tick period in ns and clock period in ns
`define AFSR_TICK_NS       10000
`define AFSR_CLK_NS        4
`define AFSR_TICK_CYC      (`AFSR_TICK_NS / `AFSR_CLK_NS)

`endif

// *** afsr_pkg.sv ***
// Types for the converter and start-up fault response block
`default_nettype none
package afsr_pkg;

   typedef enum logic [1:0]
   {
      AFSR_OFF   = 2'b00,
      AFSR_ON    = 2'b01,
      AFSR_LATCH = 2'b10,
      AFSR_WAIT  = 2'b11
   } afsr_state_t;

   // One response setting, split in its fields
   typedef struct packed
   {
      logic [1:0] action;
      logic [2:0] retry;
      logic [2:0] delay;
   } afsr_resp_t;

   // Status bundle seen by the host side
   typedef struct packed
   {
      logic [15:0] word;
      logic [7:0]  temp;
      logic [7:0]  vin;
      logic [7:0]  vout;
   } afsr_status_t;

endpackage
`default_nettype wire

// *** afsr_tick.sv ***
// 10 us timebase, resynchronised by the shared timebase pin
`default_nettype none
`include "afsr_map.svh"
module afsr_tick #(
   parameter int unsigned TICK_CYC = `AFSR_TICK_CYC
)(
   // Clock and control
   input  wire logic i_mclk,
   input  wire logic i_srst,
   input  wire logic i_ce,
   // Sync pulse and tick out
   input  wire logic i_sync,
   output logic      o_tick
);
   typedef struct packed
   {
      logic [15:0] cnt;
      logic        sync;
      logic        tick;
   } afsr_tick_st_t;

   afsr_tick_st_t st_q;
   afsr_tick_st_t st_d;

   // Rising edge of the pin restarts the period, rounding to a tick
   always_comb
   begin
      st_d      = st_q;
      st_d.sync = i_sync;
      st_d.tick = 1'b0;
      if (i_sync && !st_q.sync)
      begin
         st_d.cnt  = 16'h0000;
         st_d.tick = 1'b1;
      end
      else if (st_q.cnt == 16'(TICK_CYC - 1))
      begin
         st_d.cnt  = 16'h0000;
         st_d.tick = 1'b1;
      end
      else
         st_d.cnt = st_q.cnt + 16'h0001;
   end

   // State register
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
         st_q <= '0;
      else if (i_ce)
         st_q <= st_d;
   end

   assign o_tick = st_q.tick & i_ce;
endmodule
`default_nettype wire

// *** afsr_core.sv ***
// Fault response for converter-measured and start-up timeout faults
// What this block does
// - Converter faults set summary, detailed status bits and pull alert low.
// - Action 00b keeps running; 01b..11b shut down then follow retry.
// - Retry 000b never restarts; output stays off until latch cleared.
// - Retry 001b..111b restarts forever at retry delay until stopped.
// - Rewritten retry setting may wait for next off-then-on; here acts at once.
// - Delay field always reads 000b; no deglitch is added.
// - Converter faults act directly without any deglitch filter.
// - Timeout action 00b continues; 01b and 1Xb shut down, follow retry.
// - Timeout sets high-byte, vout word bit, timeout bit and alert.
// - Timeout retry 000b stays off; nonzero retries at retry delay.
// - Timers count a 10 us tick, resynchronised by the shared pin.
// - Retry 000b shutdown latches off; released by pin, command, config write or bias.
// - Clear-faults resets status and alert but keeps latched off state.
`default_nettype none
`include "afsr_map.svh"
module afsr_core #(
   parameter int unsigned TICK_CYC = `AFSR_TICK_CYC,
   parameter int unsigned DLY_W    = 16
)(
   // Clock, reset, enable
   input  wire logic                 i_mclk,
   input  wire logic                 i_srst,
   input  wire logic                 i_ce,
   // Response setting writes
   input  wire logic                 i_resp_we,
   input  wire logic [2:0]           i_resp_sel,
   input  wire logic [7:0]           i_resp_wdata,
   input  wire logic [DLY_W-1:0]     i_retry_delay,
   // Fault inputs, one cycle pulses or levels
   input  wire logic                 i_hot_fault,
   input  wire logic                 i_cold_fault,
   input  wire logic                 i_supply_high_fault,
   input  wire logic                 i_supply_low_fault,
   input  wire logic                 i_startup_timeout,
   // Channel control
   input  wire logic                 i_channel_on_pin,
   input  wire logic                 i_operation_on,
   input  wire logic                 i_on_off_cfg_wr,
   input  wire logic                 i_bias_ok,
   input  wire logic                 i_clear_faults,
   input  wire logic                 i_shared_timebase_pin,
   // Outputs
   output logic                      o_channel_en,
   output logic                      o_host_alert_n,
   output afsr_pkg::afsr_status_t    o_status,
   output logic [39:0]               o_resp_rdata
);
   typedef struct packed
   {
      logic [4:0][7:0]             resp;
      afsr_pkg::afsr_state_t       fsm;
      logic [DLY_W-1:0]            wait_cnt;
      logic                        pin_q;
      logic                        op_q;
      afsr_pkg::afsr_status_t      status;
      logic                        alert;
   } afsr_core_st_t;

   afsr_core_st_t st_q;
   afsr_core_st_t st_d;
   logic          tick;
   logic [4:0]    faults;
   logic          want_on;
   logic          release_evt;
   logic          shut;
   logic [2:0]    shut_retry;

   // Decode one setting into its fields
   function automatic afsr_pkg::afsr_resp_t afsr_split(input logic [7:0] r);
      afsr_pkg::afsr_resp_t f;
      f.action = r[`AFSR_ACT_HI:`AFSR_ACT_LO];
      f.retry  = r[`AFSR_RETRY_HI:`AFSR_RETRY_LO];
      f.delay  = `AFSR_DELAY_FIXED;
      return f;
   endfunction

   afsr_tick #(.TICK_CYC(TICK_CYC)) u_tick (
      .i_mclk (i_mclk),
      .i_srst (i_srst),
      .i_ce   (i_ce),
      .i_sync (i_shared_timebase_pin),
      .o_tick (tick)
   );

   // Faults are used as they arrive, no filter stage
   assign faults  = {i_startup_timeout, i_supply_low_fault,
                     i_supply_high_fault, i_cold_fault, i_hot_fault};
   assign want_on = i_channel_on_pin & i_operation_on & i_bias_ok;
   // Toggle of pin or command, config write, or bias loss frees latch
   assign release_evt = (!i_channel_on_pin && st_q.pin_q)
                      | (!i_operation_on && st_q.op_q)
                      | i_on_off_cfg_wr | !i_bias_ok;

   // Pick the shutting fault; lowest source index wins on a tie
   always_comb
   begin
      afsr_pkg::afsr_resp_t f;
      shut       = 1'b0;
      shut_retry = 3'h0;
      f          = afsr_split(8'h00);
      for (int i = 4; i >= 0; i--)
      begin
         f = afsr_split(st_q.resp[i]);
         // Nonzero action shuts down, timeout 01b included
         if (faults[i] && f.action != 2'b00)
         begin
            shut       = 1'b1;
            // Live setting read at fault time, no stale copy kept
            shut_retry = f.retry;
         end
      end
   end

   // Next state
   always_comb
   begin
      st_d       = st_q;
      st_d.pin_q = i_channel_on_pin;
      st_d.op_q  = i_operation_on;

      // Response settings; delay field forced to zero
      if (i_resp_we && i_resp_sel <= `AFSR_SRC_TON)
         st_d.resp[i_resp_sel] = {i_resp_wdata[7:3], `AFSR_DELAY_FIXED};

      // Status clear first, so a fault in the same cycle wins
      if (i_clear_faults)
      begin
         st_d.status = '0;
         st_d.alert  = 1'b0;
      end
      // Converter faults: summary, detail, alert
      if (i_hot_fault)
      begin
         st_d.status.word[`AFSR_SW_TEMP] = 1'b1;
         st_d.status.temp[`AFSR_TEMP_OT] = 1'b1;
      end
      if (i_cold_fault)
      begin
         st_d.status.word[`AFSR_SW_TEMP] = 1'b1;
         st_d.status.temp[`AFSR_TEMP_UT] = 1'b1;
      end
      if (i_supply_high_fault)
      begin
         st_d.status.word[`AFSR_SW_INPUT] = 1'b1;
         st_d.status.vin[`AFSR_VIN_OV]    = 1'b1;
      end
      if (i_supply_low_fault)
      begin
         st_d.status.word[`AFSR_SW_INPUT]  = 1'b1;
         st_d.status.word[`AFSR_SW_VIN_UV] = 1'b1;
         st_d.status.vin[`AFSR_VIN_UV]     = 1'b1;
      end
      // Timeout: high-byte, vout summary, timeout detail
      if (i_startup_timeout)
      begin
         st_d.status.word[`AFSR_SW_HIGH_BYTE] = 1'b1;
         st_d.status.word[`AFSR_SW_VOUT]      = 1'b1;
         st_d.status.vout[`AFSR_VOUT_TON]     = 1'b1;
      end
      if (|faults)
         st_d.alert = 1'b1;

      // Channel sequencing
      unique case (st_q.fsm)
         afsr_pkg::AFSR_OFF:
         begin
            if (want_on)
               st_d.fsm = afsr_pkg::AFSR_ON;
         end
         afsr_pkg::AFSR_ON:
         begin
            if (!want_on)
               st_d.fsm = afsr_pkg::AFSR_OFF;
            else if (shut)
            begin
               // Retry of the shutting fault picks latch or wait
               st_d.fsm = (shut_retry == 3'h0) ? afsr_pkg::AFSR_LATCH
                                               : afsr_pkg::AFSR_WAIT;
               st_d.wait_cnt = i_retry_delay;
            end
         end
         afsr_pkg::AFSR_LATCH:
         begin
            // Clear-faults alone does not free it
            if (release_evt)
               st_d.fsm = afsr_pkg::AFSR_OFF;
         end
         afsr_pkg::AFSR_WAIT:
         begin
            if (release_evt)
               st_d.fsm = afsr_pkg::AFSR_OFF; // Off command ends retry
            else if (shut)
            begin
               // New fault restarts sequence with its own setting
               st_d.fsm = (shut_retry == 3'h0) ? afsr_pkg::AFSR_LATCH
                                               : afsr_pkg::AFSR_WAIT;
               st_d.wait_cnt = i_retry_delay;
            end
            else if (st_q.wait_cnt == '0)
               st_d.fsm = afsr_pkg::AFSR_ON; // Retry forever
            else if (tick)
               st_d.wait_cnt = st_q.wait_cnt - 1'b1; // Tick timed
         end
      endcase
   end

   // State register
   always_ff @(posedge i_mclk)
   begin
      if (i_srst)
      begin
         st_q      <= '0;
         st_q.resp <= {5{`AFSR_RESP_RESET}};
         st_q.fsm  <= afsr_pkg::AFSR_OFF;
      end
      else if (i_ce)
         st_q <= st_d;
   end

   // Outputs from flip-flops
   assign o_channel_en   = (st_q.fsm == afsr_pkg::AFSR_ON);
   assign o_host_alert_n = !st_q.alert;
   always_comb
   begin
      o_status = st_q.status;
      // Off summary mirrors live channel state
      o_status.word[`AFSR_SW_OFF] = (st_q.fsm != afsr_pkg::AFSR_ON);
   end
   assign o_resp_rdata = st_q.resp;
endmodule
`default_nettype wire

// *** afsr_core_asserts.sv ***
// Checker for the fault response block ports
`default_nettype none
module afsr_core_asserts (
   // Clock, reset and inputs
   input wire logic                   i_mclk,
   input wire logic                   i_srst,
   input wire logic                   i_ce,
   input wire logic [4:0]             i_flt,
   input wire logic                   i_clear_faults,
   // Outputs watched
   input wire logic                   o_channel_en,
   input wire logic                   o_host_alert_n,
   input wire afsr_pkg::afsr_status_t o_status,
   input wire logic [39:0]            o_resp_rdata
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   // Hot fault acts at once, no deglitch on the slow converter path
   hot_shutdown_a: assert property (
      i_ce && i_flt[0] && o_channel_en && o_resp_rdata[7:6] != 2'h0
      |=> !o_channel_en) else $error("hot fault did not shut down");
   hot_status_a: assert property (
      i_ce && i_flt[0] |=> o_status.word[2] && o_status.temp[7]
      && !o_host_alert_n) else $error("hot fault status missing");
   low_status_a: assert property (
      i_ce && i_flt[3] |=> o_status.word[13] && o_status.word[3]
      && o_status.vin[4]) else $error("supply low status missing");
   delay_zero_a: assert property (
      (o_resp_rdata & 40'h0707070707) == 40'h0)
      else $error("delay field not zero");
   ton_status_a: assert property (
      i_ce && i_flt[4] |=> o_status.word[15] && o_status.word[0]
      && o_status.vout[2] && !o_host_alert_n)
      else $error("timeout status missing");
   ton_shutdown_a: assert property (
      i_ce && i_flt[4] && o_channel_en && o_resp_rdata[39:38] != 2'h0
      |=> !o_channel_en) else $error("timeout did not shut down");
   // Clear wins only when no fault arrives in the same cycle
   clear_alert_a: assert property (
      i_ce && i_clear_faults && i_flt == 5'h00 |=> o_host_alert_n
      && (o_status.word & 16'hFFBF) == 16'h0000)
      else $error("clear did not release status");
   retry_zero_a: assert property (
      i_ce && i_flt[0] && o_channel_en && o_resp_rdata[7:6] != 2'h0
      && o_resp_rdata[5:3] == 3'h0 |=> (!o_channel_en)[*4])
      else $error("restart with retry zero");
endmodule
bind afsr_core afsr_core_asserts i_afsr_core_asserts (
   .i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce),
   .i_flt({i_startup_timeout, i_supply_low_fault, i_supply_high_fault,
      i_cold_fault, i_hot_fault}),
   .i_clear_faults(i_clear_faults), .o_channel_en(o_channel_en),
   .o_host_alert_n(o_host_alert_n), .o_status(o_status),
   .o_resp_rdata(o_resp_rdata));
`default_nettype wire

// *** afsr_far_side.sv ***
// Far side model: host on/off requests and bias supply
`default_nettype none
module afsr_far_side (
   // Clock and requests from the bench
   input  wire logic i_mclk,
   input  wire logic i_srst,
   input  wire logic i_want,
   input  wire logic i_bias,
   // Levels toward the block
   output logic      o_on_pin,
   output logic      o_op_on,
   output logic      o_bias_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pin and command move together; dropping them releases a latch
   always_ff @(posedge i_mclk)
   begin
      o_on_pin  <= !i_srst && i_want;
      o_op_on   <= !i_srst && i_want;
      o_bias_ok <= !i_srst && i_bias;
   end
endmodule
`default_nettype wire

// *** afsr_core_bench.sv ***
// Self-checking bench for the fault response block
`default_nettype none
module afsr_core_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // Expected status {word,temp,vin,vout} per converter fault
   localparam logic [39:0] EXP [4] = '{40'h0044800000, 40'h0044400000,
      40'h2040008000, 40'h2048001000};
   logic                   i_mclk, i_srst, we, clr, cfg, sync, want;
   logic                   on_pin, op_on, bias_ok, en, alert_n;
   logic [2:0]             sel;
   logic [7:0]             wdata;
   logic [15:0]            dly;
   logic [4:0]             flt;
   logic [39:0]            rdata;
   afsr_pkg::afsr_status_t status;
   int                     n_fail = 0;
   int                     total_checks = 0;

   // Short tick keeps retry waits brief
   afsr_core #(.TICK_CYC(4), .DLY_W(16)) i_afsr_core (
      .i_mclk(i_mclk), .i_srst(i_srst), .i_ce(1'b1), .i_resp_we(we),
      .i_resp_sel(sel), .i_resp_wdata(wdata), .i_retry_delay(dly),
      .i_hot_fault(flt[0]), .i_cold_fault(flt[1]),
      .i_supply_high_fault(flt[2]), .i_supply_low_fault(flt[3]),
      .i_startup_timeout(flt[4]), .i_channel_on_pin(on_pin),
      .i_operation_on(op_on), .i_on_off_cfg_wr(cfg), .i_bias_ok(bias_ok),
      .i_clear_faults(clr), .i_shared_timebase_pin(sync),
      .o_channel_en(en), .o_host_alert_n(alert_n), .o_status(status),
      .o_resp_rdata(rdata));
   afsr_far_side i_afsr_far_side (.i_mclk(i_mclk), .i_srst(i_srst),
      .i_want(want), .i_bias(1'b1), .o_on_pin(on_pin), .o_op_on(op_on),
      .o_bias_ok(bias_ok));

   // Verdict and shared helpers
   task automatic end_of_test();
      if (n_fail == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic wr(input logic [2:0] s, input logic [7:0] d);
      @(posedge i_mclk);
      we <= 1'b1;
      sel <= s;
      wdata <= d;
      @(posedge i_mclk);
      we <= 1'b0;
   endtask
   task automatic pulse(input logic [4:0] m, input logic c, input logic f);
      @(posedge i_mclk);
      flt <= m;
      clr <= c;
      cfg <= f;
      @(posedge i_mclk);
      flt <= 5'h00;
      clr <= 1'b0;
      cfg <= 1'b0;
   endtask
   // Bounded wait; running out ends the run
   task automatic wait_en(input logic v);
      int k;
      k = 0;
      // Step off the edge so the enable is settled
      #1;
      while (en !== v && k < 200)
      begin
         tick(1);
         k++;
      end
      if (en !== v)
      begin
         n_fail++;
         $display("wrong value at %0t: enable wait ran out", $time);
         end_of_test();
      end
   endtask

   // Delay bits read zero, selector above four is ignored
   task automatic s_regs();
      for (int i = 0; i < 6; i++)
         wr(3'(i), 8'hFF);
      tick(2);
      chk(rdata, {5{8'hF8}});
   endtask
   // Each converter fault, every shutting action, retry zero latches
   task automatic s_latch();
      for (int s = 0; s < 4; s++)
      begin
         wr(3'(s), {2'(s % 3 + 1), 6'h00});
         want <= 1'b1;
         pulse(5'h00, 1'b0, 1'b1);
         wait_en(1'b1);
         pulse(5'(1 << s), 1'b0, 1'b0);
         tick(2);
         chk(status, EXP[s]);
         chk(40'(alert_n), 40'h0);
         chk(40'(en), 40'h0);
         pulse(5'h00, 1'b1, 1'b0);
         tick(20);
         chk(40'(en), 40'h0);
         chk(40'(alert_n), 40'h1);
         chk(status, 40'h0040000000);
         pulse(5'h00, 1'b0, 1'b1);
         wait_en(1'b1);
      end
   endtask
   // Nonzero retry restarts after the delay, a cold fault in the wait latches it off
   task automatic s_retry();
      int k;
      wr(3'h0, 8'h48);
      dly <= 16'h0003;
      sync <= 1'b1;
      pulse(5'h01, 1'b0, 1'b0);
      tick(2);
      chk(40'(en), 40'h0);
      k = 0;
      while (en !== 1'b1 && k < 100)
      begin
         tick(1);
         k++;
      end
      if (en !== 1'b1)
      begin
         n_fail++;
         $display("wrong value at %0t: retry wait ran out", $time);
         end_of_test();
      end
      chk(40'(k >= 4 && k <= 16), 40'h1);
      // Cold fault in the wait uses its own retry-zero setting
      pulse(5'h01, 1'b0, 1'b0);
      tick(2);
      pulse(5'h02, 1'b0, 1'b0);
      tick(30);
      chk(40'(en), 40'h0);
      @(posedge i_mclk);
      want <= 1'b0;
      wait_en(1'b0);
      pulse(5'h00, 1'b1, 1'b0);
   endtask
   // Timeout with every action code, retry zero
   task automatic s_ton();
      for (int a = 0; a < 4; a++)
      begin
         wr(3'h4, {2'(a), 6'h00});
         want <= 1'b1;
         pulse(5'h00, 1'b0, 1'b1);
         wait_en(1'b1);
         pulse(5'h10, 1'b0, 1'b0);
         tick(2);
         chk(status, a == 0 ? 40'h8001000004 : 40'h8041000004);
         chk(40'(en), 40'(a == 0));
         pulse(5'h00, 1'b1, 1'b0);
      end
   endtask

   // Clock
   initial
   begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   // Main sequence
   initial
   begin
      i_srst = 1'b1;
      {we, clr, cfg, sync, want} = 5'h00;
      sel = 3'h0;
      wdata = 8'h00;
      dly = 16'h0000;
      flt = 5'h00;
      repeat (12) @(posedge i_mclk);
      i_srst <= 1'b0;
      tick(1);
      chk({rdata[38:0], alert_n}, 40'h1);
      s_regs();
      s_latch();
      s_retry();
      s_ton();
      end_of_test();
   end
endmodule
`default_nettype wire
